//--- inc/spp_pkg.sv
package spp_pkg;

    // ----------------------------------------
    // Link format and sizing
    // ----------------------------------------
    localparam int SPP_WORD_W = 8;
    localparam int SPP_DIV_W = 8;
    localparam int SPP_FLAGS = 4;
    // Half period must outlast the two-stage input synchroniser
    localparam int SPP_HALF_MIN = 3;

    // ----------------------------------------
    // Pin levels
    // ----------------------------------------
    localparam logic SPP_SEL_ACTIVE = 1'b0;
    localparam logic SPP_SEL_IDLE = 1'b1;
    localparam logic SPP_OD_LOW = 1'b0;

    typedef enum logic [0:0] {
        st_idle,
        st_run
    } spp_state_e;

endpackage : spp_pkg

//--- src/spp_slave_link.sv
`timescale 1ns/1ps

module spp_slave_link
    import spp_pkg::*;
#(
    parameter int WORD_W = SPP_WORD_W
)
(
    input wire logic link_clk,
    input wire logic frame_rst,
    input wire logic word_rst,
    input wire logic invert,
    input wire logic [WORD_W-1:0] tx_word,
    input wire logic mosi_in,
    output logic miso_bit,
    output logic [WORD_W-1:0] rx_word,
    output logic done_tgl
);

    localparam int CW = $clog2(WORD_W);
    localparam logic [CW-1:0] LAST = CW'(WORD_W - 1);

    if (WORD_W < 2)
        $error("spp_slave_link: WORD_W must be at least 2");

    // ----------------------------------------
    // Effective clock
    // ----------------------------------------
    // Sample edge is the rising edge of this clock in every mode;
    // invert is static while the port is enabled, so no runt pulses
    logic eff_clk;
    assign eff_clk = link_clk ^ invert;

    logic [CW-1:0] cnt_q;
    logic [WORD_W-1:0] rx_sr_q;
    logic out_q;
    logic launched_q;
    logic [CW-1:0] tx_idx;
    logic word_end;

    assign word_end = (cnt_q == LAST);
    assign tx_idx = LAST - cnt_q;

    // ----------------------------------------
    // Sample side
    // ----------------------------------------
    // Select high holds the counter, so stray edges are ignored
    always_ff @(posedge eff_clk or posedge frame_rst)
    begin
        if (frame_rst)
            cnt_q <= '0;
        else
            cnt_q <= word_end ? '0 : cnt_q + 1'b1;
    end

    // Data is taken on the edge opposite to launch
    always_ff @(posedge eff_clk)
    begin
        rx_sr_q <= {rx_sr_q[WORD_W-2:0], mosi_in};
    end

    // Toggle survives frames; it carries word completion to the core
    always_ff @(posedge eff_clk or posedge word_rst)
    begin
        if (word_rst)
        begin
            done_tgl <= 1'b0;
            rx_word <= '0;
        end
        else if (word_end && !frame_rst)
        begin
            done_tgl <= ~done_tgl;
            rx_word <= {rx_sr_q[WORD_W-2:0], mosi_in};
        end
    end

    // ----------------------------------------
    // Launch side
    // ----------------------------------------
    // Same index works for both phases: leading launch shows bit 7 first
    always_ff @(negedge eff_clk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            out_q <= 1'b0;
            launched_q <= 1'b0;
        end
        else
        begin
            out_q <= tx_word[tx_idx];
            launched_q <= 1'b1;
        end
    end

    // First bit sits on the line before any edge when phase is zero
    assign miso_bit = launched_q ? out_q : tx_word[WORD_W-1];

endmodule : spp_slave_link

//--- src/spp_port.sv
`timescale 1ns/1ps

module spp_port
    import spp_pkg::*;
#(
    parameter int WORD_W = SPP_WORD_W,
    parameter int DIV_W = SPP_DIV_W,
    parameter int NFLAG = SPP_FLAGS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_link_clock,
    input wire logic enable,
    input wire logic master_mode,
    input wire logic clk_polarity,
    input wire logic clk_phase,
    input wire logic open_drain_enable,
    input wire logic slave_out_disable,
    input wire logic [DIV_W-1:0] half_period,
    input wire logic [NFLAG-1:0] flag_select,
    input wire logic [WORD_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [WORD_W-1:0] rx_data,
    output logic rx_valid,
    output logic busy,
    output logic mm_error,
    input wire logic mm_error_clear,
    input wire logic slave_select_in_n,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    output logic [NFLAG-1:0] general_flag_pins_out,
    output logic [NFLAG-1:0] general_flag_pins_oe
);

    localparam int EW = $clog2(2 * WORD_W);
    localparam logic [EW-1:0] LAST_EDGE = EW'(2 * WORD_W - 1);
    localparam logic [DIV_W-1:0] HALF_MIN = DIV_W'(SPP_HALF_MIN);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (WORD_W < 2)
        $error("spp_port: WORD_W must be at least 2");
    if (DIV_W < 2 || (1 << DIV_W) <= SPP_HALF_MIN)
        $error("spp_port: DIV_W too small for minimum half period");
    if (NFLAG < 1)
        $error("spp_port: NFLAG must be at least 1");

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic master_en;
    logic slave_en;
    assign master_en = enable && master_mode;
    assign slave_en = enable && !master_mode;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sel_s1_q;
    logic sel_s2_q;
    logic miso_s1_q;
    logic miso_s2_q;
    logic done_s1_q;
    logic done_s2_q;
    logic done_s3_q;
    logic done_tgl;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sel_s1_q <= SPP_SEL_IDLE;
            sel_s2_q <= SPP_SEL_IDLE;
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end
        else
        begin
            sel_s1_q <= slave_select_in_n;
            sel_s2_q <= sel_s1_q;
            miso_s1_q <= miso_in;
            miso_s2_q <= miso_s1_q;
            done_s1_q <= done_tgl;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    // ----------------------------------------
    // Multimaster error
    // ----------------------------------------
    logic mm_err_q;
    logic mm_err_d;
    logic mm_set;
    // Set wins over a clear in the same cycle
    assign mm_set = master_en && (sel_s2_q == SPP_SEL_ACTIVE);
    assign mm_err_d = mm_set || (mm_err_q && !mm_error_clear);
    assign mm_error = mm_err_q;

    always_ff @(posedge clk)
    begin
        if (rst)
            mm_err_q <= 1'b0;
        else
            mm_err_q <= mm_err_d;
    end

    // ----------------------------------------
    // Master engine
    // ----------------------------------------
    spp_state_e state_q;
    logic [DIV_W-1:0] half_cnt_q;
    logic [EW-1:0] edge_cnt_q;
    logic sclk_q;
    logic [WORD_W-1:0] tx_sr_q;
    logic [WORD_W-1:0] rx_sr_q;
    logic [WORD_W-1:0] tx_hold_q;
    logic [NFLAG-1:0] flags_q;
    logic [WORD_W-1:0] rx_data_q;
    logic rx_valid_q;

    logic running;
    logic tick;
    logic sample_now;
    logic launch_now;
    logic last_edge;
    logic start;
    logic load_slave;
    logic [DIV_W-1:0] half_eff;
    logic [WORD_W-1:0] rx_shift;
    logic [WORD_W-1:0] rx_next;
    logic slave_done;
    logic [WORD_W-1:0] slave_rx_word;
    logic slave_bit;

    assign running = (state_q == st_run);
    // Too short a half period would outrun the data synchroniser
    assign half_eff = (half_period < HALF_MIN) ? HALF_MIN : half_period;
    assign tick = running && (half_cnt_q == '0);
    // Phase zero samples leading edges, phase one trailing edges
    assign sample_now = tick && (edge_cnt_q[0] == clk_phase);
    assign launch_now = tick && !sample_now && (edge_cnt_q != '0);
    assign last_edge = tick && (edge_cnt_q == LAST_EDGE);
    assign rx_shift = {rx_sr_q[WORD_W-2:0], miso_s2_q};
    assign rx_next = sample_now ? rx_shift : rx_sr_q;

    assign tx_ready = master_en ? (!running && !mm_err_q) :
                      (slave_en && sel_s2_q == SPP_SEL_IDLE);
    assign start = master_en && tx_valid && tx_ready;
    assign load_slave = slave_en && tx_valid && tx_ready;
    assign busy = running || (slave_en && sel_s2_q == SPP_SEL_ACTIVE);

    always_ff @(posedge clk)
    begin
        if (rst || !master_en || mm_err_d)
            state_q <= st_idle;
        else if (start)
            state_q <= st_run;
        else if (last_edge)
            state_q <= st_idle;
    end

    always_ff @(posedge clk)
    begin
        if (rst || !running)
            half_cnt_q <= half_eff;
        else
            half_cnt_q <= tick ? half_eff : half_cnt_q - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst || !running)
            edge_cnt_q <= '0;
        else if (tick)
            edge_cnt_q <= edge_cnt_q + 1'b1;
    end

    // Clock rests at its idle level outside words
    always_ff @(posedge clk)
    begin
        if (rst || !running)
            sclk_q <= clk_polarity;
        else if (tick)
            sclk_q <= ~sclk_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            tx_sr_q <= '0;
        else if (start)
            tx_sr_q <= tx_data;
        else if (launch_now)
            tx_sr_q <= {tx_sr_q[WORD_W-2:0], 1'b0};
    end

    always_ff @(posedge clk)
    begin
        if (rst || start)
            rx_sr_q <= '0;
        else
            rx_sr_q <= rx_next;
    end

    // Slave transmit word is only changed while deselected
    always_ff @(posedge clk)
    begin
        if (rst)
            tx_hold_q <= '0;
        else if (load_slave)
            tx_hold_q <= tx_data;
    end

    // Flags chosen as selects go low for the whole word
    always_ff @(posedge clk)
    begin
        if (rst || !running)
            flags_q <= {NFLAG{SPP_SEL_IDLE}};
        else
            flags_q <= {NFLAG{SPP_SEL_ACTIVE}};
    end

    // ----------------------------------------
    // Received words
    // ----------------------------------------
    assign slave_done = slave_en && (done_s2_q != done_s3_q);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_data_q <= '0;
            rx_valid_q <= 1'b0;
        end
        else
        begin
            rx_valid_q <= (master_en && last_edge) || slave_done;
            if (master_en && last_edge)
                rx_data_q <= rx_next;
            else if (slave_done)
                rx_data_q <= slave_rx_word;
        end
    end

    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;

    // ----------------------------------------
    // Slave link domain
    // ----------------------------------------
    logic frame_rst;
    logic invert;
    // Deselect or leaving slave mode ends the frame without a link edge
    assign frame_rst = slave_select_in_n || !slave_en;
    assign invert = (clk_polarity != clk_phase);

    spp_slave_link #(
        .WORD_W(WORD_W)
    ) u_link (
        .link_clk(serial_link_clock),
        .frame_rst(frame_rst),
        .word_rst(rst),
        .invert(invert),
        .tx_word(tx_hold_q),
        .mosi_in(mosi_in),
        .miso_bit(slave_bit),
        .rx_word(slave_rx_word),
        .done_tgl(done_tgl)
    );

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic drive_master;
    logic slave_talk;
    // Drivers drop as soon as a contending master shows up
    assign drive_master = master_en && !mm_err_q;
    assign sclk_out = sclk_q;
    assign sclk_oe = drive_master;
    assign mosi_out = tx_sr_q[WORD_W-1];
    assign mosi_oe = drive_master;

    // Only a selected, non-disabled slave may talk on master-in
    assign slave_talk = slave_en && !slave_select_in_n && !slave_out_disable;
    assign miso_out = open_drain_enable ? SPP_OD_LOW : slave_bit;
    assign miso_oe = slave_talk && (!open_drain_enable || !slave_bit);

    assign general_flag_pins_out = flags_q;
    assign general_flag_pins_oe = drive_master ? flag_select : '0;

endmodule : spp_port

//--- verif/spp_port_asserts.sv
`timescale 1ns/1ps

module spp_port_chk
    import spp_pkg::*;
#(
    parameter int DIV_W = SPP_DIV_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic master_mode,
    input wire logic clk_polarity,
    input wire logic open_drain_enable,
    input wire logic slave_out_disable,
    input wire logic [DIV_W-1:0] half_period,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic busy,
    input wire logic mm_error,
    input wire logic mm_error_clear,
    input wire logic slave_select_in_n,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic mosi_oe,
    input wire logic miso_out,
    input wire logic miso_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Word latency counter
    // ----------------------------------------
    logic armed_q;
    logic [11:0] cnt_q;
    wire logic take = master_mode && enable && tx_valid && tx_ready;
    wire logic [DIV_W-1:0] eff = (half_period < DIV_W'(SPP_HALF_MIN)) ? DIV_W'(SPP_HALF_MIN)
        : half_period;
    wire logic [11:0] lat = 12'((eff + 1) * 16 + 1);

    always_ff @(posedge clk)
    begin
        if (rst || mm_error)
            armed_q <= 1'b0;
        else if (take)
            armed_q <= 1'b1;
        else if (rx_valid)
            armed_q <= 1'b0;
        cnt_q <= take ? 12'h001 : cnt_q + 12'h001;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence mm_contest;
        master_mode && enable && $fell(slave_select_in_n) ##1 !slave_select_in_n [*2];
    endsequence

    a_idle_clk_level:
    assert property (master_mode && enable && !busy && sclk_oe && $stable(clk_polarity)
        && $stable(busy) && $stable(master_mode) |-> sclk_out == clk_polarity)
        else $error("serial clock not at idle level");
    a_word_latency:
    assert property (armed_q && rx_valid |-> cnt_q == lat)
        else $error("word length in clocks wrong");
    a_mm_raise:
    assert property (mm_contest |-> ##[0:2] mm_error)
        else $error("contention not flagged");
    a_mm_quiet:
    assert property (mm_error |-> !sclk_oe && !mosi_oe)
        else $error("drives during contention");
    a_mm_sticky:
    assert property (mm_error && !mm_error_clear |=> mm_error)
        else $error("error flag lost");
    a_miso_off:
    assert property (slave_out_disable |-> !miso_oe)
        else $error("slave out driven while disabled");
    a_od_pull_low:
    assert property (open_drain_enable && miso_oe |-> miso_out == SPP_OD_LOW)
        else $error("open drain drives high");
    a_master_miso_in:
    assert property (master_mode && $stable(master_mode) |-> !miso_oe)
        else $error("master drives slave out line");
    a_slave_no_drive:
    assert property (enable && !master_mode && $stable(master_mode) |-> !sclk_oe && !mosi_oe)
        else $error("slave drives clock or master out");
endmodule : spp_port_chk

bind spp_port spp_port_chk #(.DIV_W(DIV_W)) chk_u (.*);

//--- verif/spp_partner.sv
`timescale 1ns/1ps

module spp_partner
(
    input wire logic sck,
    input wire logic sel_n,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic mosi,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic ob = 1'b1;
    int idx = 0;

    // Released line reads as the pull-up level
    assign miso = sel_n ? 1'b1 : ob;

    always @(negedge sel_n)
    begin
        ob = tx[7];
        idx = cpha ? 7 : 6;
    end

    // Past the last bit the line no longer holds data
    always @(sck)
    begin
        if (!sel_n)
        begin
            if ((sck != cpol) ^ cpha)
                rx = {rx[6:0], mosi};
            else
            begin
                ob = (idx >= 0) ? tx[idx] : ~ob;
                idx--;
            end
        end
    end
endmodule : spp_partner

//--- verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import spp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mm = 1'b1, cpol = 1'b0, cpha = 1'b0, od = 1'b0, sod = 1'b0, en = 1'b1;
    logic txv = 1'b0, clr = 1'b0, sel_n = 1'b1, bsck = 1'b0, bmosi = 1'b1, got = 1'b0;
    logic [7:0] hp = 8'h03, txd = 8'h00, ptx = 8'h00, rxd, rx_data, prx;
    logic [3:0] fsel = 4'h1, fpo, fpoe;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, txr, rxv, busy, mmerr, pmiso;
    int errors = 0;
    int checked = 0;
    wire logic sck_w = mm ? (sclk_oe ? sclk_out : 1'b1) : bsck;
    wire logic mosi_w = mosi_oe ? mosi_out : (mm ? 1'b1 : bmosi);
    wire logic miso_w = miso_oe ? miso_out : (mm ? pmiso : 1'b1);
    wire logic psel_n = fpoe[0] ? fpo[0] : 1'b1;

    initial
    begin
        forever #50 clk = ~clk;
    end

    spp_port dut_u (.clk(clk), .rst(rst), .serial_link_clock(sck_w), .enable(en),
        .master_mode(mm), .clk_polarity(cpol), .clk_phase(cpha), .open_drain_enable(od),
        .slave_out_disable(sod), .half_period(hp), .flag_select(fsel), .tx_data(txd),
        .tx_valid(txv), .tx_ready(txr), .rx_data(rx_data), .rx_valid(rxv), .busy(busy),
        .mm_error(mmerr), .mm_error_clear(clr), .slave_select_in_n(sel_n),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
        .general_flag_pins_out(fpo), .general_flag_pins_oe(fpoe));

    spp_partner part_u (.sck(sck_w), .sel_n(psel_n), .cpol(cpol), .cpha(cpha),
        .mosi(mosi_w), .tx(ptx), .miso(pmiso), .rx(prx));

    always @(posedge clk)
    begin
        if (rxv)
        begin
            got <= 1'b1;
            rxd <= rx_data;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Disabled slave output leaves the line at its pull-up level
    function automatic logic [7:0] exp_miso(input logic [7:0] d);
        return sod ? 8'hff : d;
    endfunction : exp_miso

    // Every chosen flag pin is driven, and all of them are low during a word
    function automatic logic [7:0] exp_flags(input logic [3:0] s);
        return {4'h0, s};
    endfunction : exp_flags

    task automatic wait_got(input int n);
        for (int i = 0; i < n && !got; i++)
            @(negedge clk);
        if (!got)
        begin
            errors++;
            test_done();
        end
    endtask : wait_got

    task automatic mword(input logic [7:0] d, input logic [7:0] p);
        ptx = p;
        txd = d;
        txv = 1'b1;
        got = 1'b0;
        @(negedge clk);
        txv = 1'b0;
        @(negedge clk);
        chk({fpo, fpoe}, exp_flags(fsel));
        chk({6'h00, busy, txr}, 8'h02);
        wait_got(300);
        chk(rxd, p);
        chk(prx, d);
    endtask : mword

    // Bench plays master; link clock also pulses twice before the frame opens
    task automatic sword(input logic [7:0] d, input logic [7:0] b);
        logic [7:0] r;
        txd = d;
        txv = 1'b1;
        got = 1'b0;
        repeat (4) @(negedge clk);
        txv = 1'b0;
        bmosi = ~b[7];
        repeat (2)
        begin
            #80 bsck = ~cpol;
            #80 bsck = cpol;
        end
        bmosi = b[7];
        #37 sel_n = 1'b0;
        #337;
        chk({6'h00, busy, txr}, 8'h02);
        for (int i = 7; i >= 0; i--)
        begin
            #80 bsck = ~cpol;
            if (!cpha) r = {r[6:0], miso_w}; else bmosi = b[i];
            #80 bsck = cpol;
            if (cpha) r = {r[6:0], miso_w}; else bmosi = (i > 0) ? b[i-1] : ~bmosi;
        end
        wait_got(20);
        sel_n = 1'b1;
        chk(rxd, b);
        chk(r, exp_miso(d));
        repeat (4) @(negedge clk);
    endtask : sword

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h4d2a4b1d));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        for (int m = 0; m < 4; m++)
        begin
            {cpol, cpha} = 2'(m);
            for (int i = 0; i < 3; i++)
            begin
                hp = 8'($urandom_range(6, 0));
                fsel = {3'($urandom), 1'b1};
                mword((i == 0) ? 8'h80 : 8'($urandom), (i == 0) ? 8'h01 : 8'($urandom));
            end
        end
        txd = 8'($urandom);
        txv = 1'b1;
        got = 1'b0;
        @(negedge clk);
        txv = 1'b0;
        repeat (20) @(negedge clk);
        sel_n = 1'b0;
        repeat (5) @(negedge clk);
        chk({7'h00, mmerr}, 8'h01);
        chk({7'h00, sclk_oe}, 8'h00);
        clr = 1'b1;
        @(negedge clk);
        chk({7'h00, mmerr}, 8'h01);
        clr = 1'b0;
        sel_n = 1'b1;
        repeat (200) @(negedge clk);
        chk({7'h00, got}, 8'h00);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        chk({7'h00, mmerr}, 8'h00);
        en = 1'b0;
        @(negedge clk);
        chk({3'h0, sclk_oe, mosi_oe, miso_oe, txr, busy}, 8'h00);
        chk({4'h0, fpoe}, 8'h00);
        en = 1'b1;
        mm = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            {cpol, cpha} = 2'(m);
            bsck = cpol;
            od = (m == 2);
            sod = (m == 3);
            sword(8'h7e, 8'h81);
            sword(8'($urandom), 8'($urandom));
        end
        test_done();
    end
endmodule : tb_top
